// ### include/multi_timer_defines.vh
`ifndef MULTI_TIMER_DEFINES_VH
`define MULTI_TIMER_DEFINES_VH

// Register byte offsets
`define OFS_PRESCALER_CONTROL 8'h00
`define OFS_PRESCALER_RELOAD 8'h04
`define OFS_TIMER_ONE_CONTROL 8'h08
`define OFS_TIMER_ONE_DATA 8'h0C
`define OFS_TIMER_ONE_RELOAD 8'h10
`define OFS_TIMER_TWO_CONTROL 8'h14
`define OFS_TIMER_TWO_DATA 8'h18
`define OFS_PWM_HIGH_RELOAD 8'h1C
`define OFS_TIMER_TWO_RESTORE 8'h20
`define OFS_TIMER_THREE_CONTROL 8'h24
`define OFS_DISPLAY_TIMER_CONTROL 8'h28
`define OFS_TIMER_THREE_SOURCE 8'h2C
`define OFS_DISPLAY_TIMER_DATA 8'h30
`define OFS_INT_CONTROL 8'h34
`define OFS_IRQ_FLAGS 8'h38
`define OFS_TIMER_THREE_COUNT 8'h3C

// Field positions
`define PRESCALER_RUN_BIT 0
`define T1_SRC_LSB 0
`define T1_RUN_BIT 2
`define T1_AUTOSTOP_BIT 3
`define T2_SRC_BIT 0
`define T2_RUN_BIT 1
`define T2_EXTEND_BIT 2
`define T2_PWM_BIT 3
`define T3_LEN_LSB 0
`define T3_RUN_BIT 3
`define DT_EDGE_BIT 0
`define DT_GATE_BIT 1
`define DT_SRC_BIT 2
`define DT_RUN_BIT 3
`define T3_SRC_LSB 0
`define START_TRIG_BIT 0
`define T3_TAP_BIT 4

// Timer one sources
`define T1_SRC_PRESCALER 2'h0
`define T1_SRC_COUNTER_PIN 2'h1
`define T1_SRC_INSTR 2'h2
`define T1_SRC_MAIN_XTAL 2'h3

// Reset values and timer three base length
`define RST_CTRL 4'h0
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define T3_INIT 16'hFFFF
`define T3_BASE_LEN 16'h0200

`endif

// ### rtl/multi_timer_pwm_unit.v
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "multi_timer_defines.vh"

// Notes on behaviour
// - Prescaler 8-bit down counter, divide by n+1
// - Prescaler load sets both; read returns reload
// - Timer one 8-bit, divides source by n+1
// - Timer one source bits 1:0, run bit 2
// - Timer one underflow sets flag, reloads, continues
// - Pin start trigger; bit 3 auto-stops at underflow
// - Timer two load, high write, restore operations
// - Timer two source bit 0, run bit 1
// - Timer two underflow sets flag, reloads low
// - PWM mode alternates low and high reloads
// - High interval extended by half period
// - Timer one underflow toggles PWM pin gating
// - Stop during high interval waits for underflow
// - Timer three 16-bit, length and source, run bit
// - Timer three completes count, sets flag, continues
// - Timer three stop resets counter to FFFF
// - Timer three runs in power-down, wakes system
// - Display timer 4-bit write-only, divide by n+1
// - Display timer source bit 2, run bit 3
// - Timer three length codes 512 to 65536
// - Timer three source sub, prescaler, low, high osc
// - Display source timer three bit 4 or system
// - Timer two source main crystal or prescaler/2
module multi_timer_pwm_unit #(
	parameter NUM_PINS = 6
) (
	input wire i_clk,
	input wire i_srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire i_main_crystal_input,
	input wire i_sub_crystal_input,
	input wire i_low_osc,
	input wire i_high_osc,
	input wire i_counter_pin,
	input wire i_ext_int_pin,
	input wire i_power_down_mode,
	output reg o_counter_pin_out,
	output reg o_counter_pin_oe,
	output reg o_prescaler_output,
	output reg o_display_timer_underflow,
	output reg o_wake,
	output reg o_timer_one_irq_flag,
	output reg o_timer_two_irq_flag,
	output reg o_timer_three_irq_flag
);

	function [2:0] sel_hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			sel_hit = (addr == ofs) ? 3'h1 : 3'h0;
		end
	endfunction

	// Pin synchronisers, three stages, change accepted when stages two and three agree
	wire [NUM_PINS-1:0] pin_raw;
	reg [NUM_PINS-1:0] pin_filt_q;
	reg [NUM_PINS-1:0] pin_rise_q;
	reg [NUM_PINS-1:0] pin_fall_q;
	assign pin_raw = {i_ext_int_pin, i_counter_pin, i_high_osc, i_low_osc,
		i_sub_crystal_input, i_main_crystal_input};
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g = g + 1) begin : g_sync
			reg s1_q;
			reg s2_q;
			reg s3_q;
			always @(posedge i_clk) begin
				if (i_srst) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					pin_filt_q[g] <= 1'b0;
					pin_rise_q[g] <= 1'b0;
					pin_fall_q[g] <= 1'b0;
				end else begin
					s1_q <= pin_raw[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						pin_filt_q[g] <= s3_q;
					end
					pin_rise_q[g] <= (s2_q == s3_q) && s3_q && !pin_filt_q[g];
					pin_fall_q[g] <= (s2_q == s3_q) && !s3_q && pin_filt_q[g];
				end
			end
		end
	endgenerate
	wire main_p = pin_rise_q[0];
	wire sub_p = pin_rise_q[1];
	wire low_p = pin_rise_q[2];
	wire high_p = pin_rise_q[3];
	wire ext_int_p = pin_rise_q[5];

	// Registers
	reg [3:0] pa_q;
	reg [3:0] w1_q;
	reg [3:0] w2_q;
	reg [3:0] w3_q;
	reg [3:0] w4_q;
	reg [3:0] w5_q;
	reg [3:0] intc_q;
	reg [7:0] ps_cnt_q;
	reg [7:0] ps_rel_q;
	reg [7:0] t1_cnt_q;
	reg [7:0] t1_rel_q;
	reg [7:0] t2_cnt_q;
	reg [7:0] t2_low_q;
	reg [7:0] t2_high_q;
	reg [15:0] t3_cnt_q;
	reg [3:0] dt_cnt_q;
	reg [3:0] dt_rel_q;

	// APB: answer one cycle after setup, so every access completes with no wait state
	wire setup = psel && !penable;
	wire wr = psel && penable && pwrite && pready;
	wire [7:0] wa = paddr;
	wire [3:0] wd = pwdata[3:0];
	wire [7:0] wb = pwdata[7:0];
	wire w_pa = wr && sel_hit(wa, `OFS_PRESCALER_CONTROL) != 3'h0;
	wire w_psrel = wr && sel_hit(wa, `OFS_PRESCALER_RELOAD) != 3'h0;
	wire w_w1 = wr && sel_hit(wa, `OFS_TIMER_ONE_CONTROL) != 3'h0;
	wire w_t1 = wr && sel_hit(wa, `OFS_TIMER_ONE_DATA) != 3'h0;
	wire w_t1rel = wr && sel_hit(wa, `OFS_TIMER_ONE_RELOAD) != 3'h0;
	wire w_w2 = wr && sel_hit(wa, `OFS_TIMER_TWO_CONTROL) != 3'h0;
	wire w_t2 = wr && sel_hit(wa, `OFS_TIMER_TWO_DATA) != 3'h0;
	wire w_t2h = wr && sel_hit(wa, `OFS_PWM_HIGH_RELOAD) != 3'h0;
	wire w_t2r = wr && sel_hit(wa, `OFS_TIMER_TWO_RESTORE) != 3'h0;
	wire w_w3 = wr && sel_hit(wa, `OFS_TIMER_THREE_CONTROL) != 3'h0;
	wire w_w4 = wr && sel_hit(wa, `OFS_DISPLAY_TIMER_CONTROL) != 3'h0;
	wire w_w5 = wr && sel_hit(wa, `OFS_TIMER_THREE_SOURCE) != 3'h0;
	wire w_dt = wr && sel_hit(wa, `OFS_DISPLAY_TIMER_DATA) != 3'h0;
	wire w_ic = wr && sel_hit(wa, `OFS_INT_CONTROL) != 3'h0;
	wire w_fl = wr && sel_hit(wa, `OFS_IRQ_FLAGS) != 3'h0;

	reg [31:0] rd_d;
	reg err_d;
	always @* begin
		rd_d = 32'h00000000;
		err_d = 1'b0;
		case (paddr)
			`OFS_PRESCALER_CONTROL: rd_d[3:0] = pa_q;
			`OFS_PRESCALER_RELOAD: rd_d[7:0] = ps_rel_q;
			`OFS_TIMER_ONE_CONTROL: rd_d[3:0] = w1_q;
			`OFS_TIMER_ONE_DATA: rd_d[7:0] = t1_cnt_q;
			`OFS_TIMER_TWO_CONTROL: rd_d[3:0] = w2_q;
			`OFS_TIMER_TWO_DATA: rd_d[7:0] = t2_cnt_q;
			`OFS_TIMER_THREE_CONTROL: rd_d[3:0] = w3_q;
			`OFS_DISPLAY_TIMER_CONTROL: rd_d[3:0] = w4_q;
			`OFS_TIMER_THREE_SOURCE: rd_d[3:0] = w5_q;
			`OFS_INT_CONTROL: rd_d[3:0] = intc_q;
			`OFS_IRQ_FLAGS: rd_d[2:0] = {o_timer_three_irq_flag,
				o_timer_two_irq_flag, o_timer_one_irq_flag};
			`OFS_TIMER_THREE_COUNT: rd_d[15:0] = t3_cnt_q;
			// Write-only locations read as zero
			`OFS_TIMER_ONE_RELOAD, `OFS_PWM_HIGH_RELOAD, `OFS_TIMER_TWO_RESTORE,
			`OFS_DISPLAY_TIMER_DATA: rd_d = 32'h00000000;
			default: err_d = 1'b1;
		endcase
	end

	always @(posedge i_clk) begin
		if (i_srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : rd_d;
				pslverr <= err_d;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// Count sources
	reg half_q;
	wire ps_under = pa_q[`PRESCALER_RUN_BIT] && ps_cnt_q == 8'h00;
	wire ps_half = ps_under && half_q;
	wire cnt_pin_p = w4_q[`DT_EDGE_BIT] ? pin_rise_q[4] : pin_fall_q[4];
	reg t1_src_p;
	always @* begin
		case (w1_q[`T1_SRC_LSB +: 2])
			`T1_SRC_PRESCALER: t1_src_p = ps_under;
			`T1_SRC_COUNTER_PIN: t1_src_p = cnt_pin_p;
			`T1_SRC_INSTR: t1_src_p = 1'b1;
			default: t1_src_p = main_p;
		endcase
	end
	wire t2_src_p = w2_q[`T2_SRC_BIT] ? ps_half : main_p;
	reg t3_src_p;
	always @* begin
		case (w5_q[`T3_SRC_LSB +: 2])
			2'h0: t3_src_p = sub_p;
			2'h1: t3_src_p = ps_under;
			2'h2: t3_src_p = low_p;
			default: t3_src_p = high_p;
		endcase
	end
	reg t3_tap_q;
	wire dt_src_p = w4_q[`DT_SRC_BIT] ? 1'b1 : (t3_tap_q && !t3_cnt_q[`T3_TAP_BIT]);

	// Timer one qualification
	reg sync_q;
	wire t1_go = w1_q[`T1_RUN_BIT] && (!intc_q[`START_TRIG_BIT] || sync_q);
	wire t1_under = t1_go && t1_src_p && t1_cnt_q == 8'h00;

	// Timer two state
	reg t2_run_q;
	reg pwm_q;
	reg gate_q;
	reg [15:0] per_cnt_q;
	reg [15:0] per_last_q;
	reg [15:0] ext_cnt_q;
	reg shift_q;
	// each extension toggles shift_q, moving the count pulses by half a period against the source
	wire [15:0] half_per = {1'b0, per_last_q[15:1]};
	wire t2_cnt_p = shift_q ? (per_cnt_q == half_per) : t2_src_p;
	wire t2_active = (w2_q[`T2_RUN_BIT] || t2_run_q) && ext_cnt_q == 16'h0000;
	wire t2_under = t2_active && t2_cnt_p && t2_cnt_q == 8'h00;

	wire [15:0] t3_len = `T3_BASE_LEN << w3_q[`T3_LEN_LSB +: 3];
	wire [15:0] t3_mask = t3_len - 16'h0001;
	wire t3_under = w3_q[`T3_RUN_BIT] && t3_src_p && (t3_cnt_q & t3_mask) == 16'h0000;

	always @(posedge i_clk) begin
		if (i_srst) begin
			pa_q <= `RST_CTRL;
			w1_q <= `RST_CTRL;
			w2_q <= `RST_CTRL;
			w3_q <= `RST_CTRL;
			w4_q <= `RST_CTRL;
			w5_q <= `RST_CTRL;
			intc_q <= `RST_CTRL;
			ps_cnt_q <= `RST_BYTE;
			ps_rel_q <= `RST_BYTE;
			t1_cnt_q <= `RST_BYTE;
			t1_rel_q <= `RST_BYTE;
			t2_cnt_q <= `RST_BYTE;
			t2_low_q <= `RST_BYTE;
			t2_high_q <= `RST_BYTE;
			t3_cnt_q <= `T3_INIT;
			dt_cnt_q <= `RST_NIBBLE;
			dt_rel_q <= `RST_NIBBLE;
			half_q <= 1'b0;
			sync_q <= 1'b0;
			t2_run_q <= 1'b0;
			pwm_q <= 1'b0;
			gate_q <= 1'b0;
			per_cnt_q <= 16'h0000;
			per_last_q <= 16'h0000;
			ext_cnt_q <= 16'h0000;
			shift_q <= 1'b0;
			t3_tap_q <= 1'b1;
			o_counter_pin_out <= 1'b0;
			o_counter_pin_oe <= 1'b0;
			o_prescaler_output <= 1'b0;
			o_display_timer_underflow <= 1'b0;
			o_wake <= 1'b0;
			o_timer_one_irq_flag <= 1'b0;
			o_timer_two_irq_flag <= 1'b0;
			o_timer_three_irq_flag <= 1'b0;
		end else begin
			if (w_pa) pa_q <= wd;
			if (w_w1) w1_q <= wd;
			if (w_w2) w2_q <= wd;
			if (w_w4) w4_q <= wd;
			if (w_w5) w5_q <= wd;
			if (w_ic) intc_q <= wd;
			if (w_w3) w3_q <= wd;

			if (w_psrel) begin
				ps_cnt_q <= wb;
				ps_rel_q <= wb;
			end else if (ps_under) begin
				ps_cnt_q <= ps_rel_q;
			end else if (pa_q[`PRESCALER_RUN_BIT]) begin
				ps_cnt_q <= ps_cnt_q - 8'h01;
			end
			if (ps_under) half_q <= !half_q;
			o_prescaler_output <= ps_under;

			if (!intc_q[`START_TRIG_BIT]) begin
				sync_q <= 1'b0;
			end else if (t1_under && w1_q[`T1_AUTOSTOP_BIT]) begin
				sync_q <= 1'b0;
			end else if (ext_int_p) begin
				sync_q <= 1'b1;
			end

			if (w_t1) begin
				t1_cnt_q <= wb;
				t1_rel_q <= wb;
			end else begin
				if (w_t1rel) t1_rel_q <= wb;
				if (t1_under) begin
					t1_cnt_q <= t1_rel_q;
				end else if (t1_go && t1_src_p) begin
					t1_cnt_q <= t1_cnt_q - 8'h01;
				end
			end

			if (w2_q[`T2_RUN_BIT]) begin
				t2_run_q <= pwm_q && w2_q[`T2_PWM_BIT];
			end else if (t2_under) begin
				t2_run_q <= 1'b0;
			end
			if (w_w2 && !wd[`T2_RUN_BIT] && pwm_q && w2_q[`T2_RUN_BIT]) t2_run_q <= 1'b1;

			// Source period measured so the extension can be half of it
			if (t2_src_p) begin
				per_cnt_q <= 16'h0001;
				per_last_q <= per_cnt_q;
			end else if (per_cnt_q != 16'hFFFF) begin
				per_cnt_q <= per_cnt_q + 16'h0001;
			end

			if (w_t2) begin
				t2_cnt_q <= wb;
				t2_low_q <= wb;
				pwm_q <= 1'b0;
				shift_q <= 1'b0;
			end else if (w_t2r) begin
				t2_cnt_q <= t2_low_q;
			end else if (ext_cnt_q != 16'h0000) begin
				ext_cnt_q <= ext_cnt_q - 16'h0001;
				if (ext_cnt_q == 16'h0001) pwm_q <= 1'b0;
			end else if (t2_under) begin
				if (w2_q[`T2_PWM_BIT] && !pwm_q) begin
					t2_cnt_q <= t2_high_q;
					pwm_q <= 1'b1;
				end else begin
					t2_cnt_q <= t2_low_q;
					if (w2_q[`T2_PWM_BIT] && w2_q[`T2_EXTEND_BIT] && pwm_q &&
						per_last_q[15:1] != 15'h0000) begin
						ext_cnt_q <= {1'b0, per_last_q[15:1]};
						shift_q <= !shift_q;
					end else begin
						pwm_q <= 1'b0;
					end
				end
			end else if (t2_active && t2_cnt_p) begin
				t2_cnt_q <= t2_cnt_q - 8'h01;
			end
			if (w_t2h) t2_high_q <= wb;

			if (!w1_q[`T1_RUN_BIT] || !w4_q[`DT_GATE_BIT]) begin
				gate_q <= 1'b0;
			end else if (t1_under) begin
				gate_q <= !gate_q;
			end
			o_counter_pin_oe <= w2_q[`T2_PWM_BIT];
			o_counter_pin_out <= w2_q[`T2_PWM_BIT] && pwm_q &&
				(!w4_q[`DT_GATE_BIT] || !w1_q[`T1_RUN_BIT] || gate_q);

			if (!w3_q[`T3_RUN_BIT]) begin
				t3_cnt_q <= `T3_INIT;
			end else if (t3_src_p) begin
				t3_cnt_q <= t3_cnt_q - 16'h0001;
			end
			t3_tap_q <= t3_cnt_q[`T3_TAP_BIT];
			o_wake <= t3_under && i_power_down_mode;

			if (w_dt) begin
				dt_cnt_q <= wd;
				dt_rel_q <= wd;
			end else if (w4_q[`DT_RUN_BIT] && dt_src_p) begin
				dt_cnt_q <= (dt_cnt_q == 4'h0) ? dt_rel_q : dt_cnt_q - 4'h1;
			end
			o_display_timer_underflow <= w4_q[`DT_RUN_BIT] && dt_src_p && dt_cnt_q == 4'h0;

			// Set wins over a write-one clear
			o_timer_one_irq_flag <= t1_under ||
				(o_timer_one_irq_flag && !(w_fl && pwdata[0]));
			o_timer_two_irq_flag <= t2_under ||
				(o_timer_two_irq_flag && !(w_fl && pwdata[1]));
			o_timer_three_irq_flag <= t3_under ||
				(o_timer_three_irq_flag && !(w_fl && pwdata[2]));
		end
	end

endmodule

// ### tb/multi_timer_pwm_unit_asserts.sv
`timescale 1ns/1ps
module multi_timer_pwm_unit_asserts (
	input wire i_clk,
	input wire i_srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire i_power_down_mode,
	input wire o_counter_pin_out,
	input wire o_counter_pin_oe,
	input wire o_wake,
	input wire o_timer_one_irq_flag,
	input wire o_timer_two_irq_flag,
	input wire o_timer_three_irq_flag
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// Flag clears only come through a completed write to the flag word
	wire acc_wr = psel && penable && pready && pwrite;
	wire flag_clr = acc_wr && paddr == 8'h38;

	property p_ready_next;
		psel && !penable |=> pready;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
	property p_ready_one;
		pready |=> !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready held too long");
	property p_err_zero;
		pslverr && !pwrite |-> prdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
	property p_reset_clear;
		$fell(i_srst) |-> !o_timer_one_irq_flag && !o_timer_two_irq_flag
			&& !o_timer_three_irq_flag && !o_counter_pin_oe && !o_wake;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("state after reset");
	property p_flag1_sticky;
		o_timer_one_irq_flag && !flag_clr |=> o_timer_one_irq_flag;
	endproperty
	a_flag1_sticky: assert property (p_flag1_sticky) else $error("flag one lost");
	property p_flag3_sticky;
		o_timer_three_irq_flag && !flag_clr |=> o_timer_three_irq_flag;
	endproperty
	a_flag3_sticky: assert property (p_flag3_sticky) else $error("flag three lost");
	property p_wake_mode;
		o_wake |-> $past(i_power_down_mode) && o_timer_three_irq_flag;
	endproperty
	a_wake_mode: assert property (p_wake_mode) else $error("wake without cause");
	property p_oe_follow;
		acc_wr && paddr == 8'h14 |=> ##1 o_counter_pin_oe == $past(pwdata[3], 2);
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("pin enable wrong");
	property p_out_quiet;
		!o_counter_pin_oe && !$past(o_counter_pin_oe) |-> !o_counter_pin_out;
	endproperty
	a_out_quiet: assert property (p_out_quiet) else $error("pin active while off");
endmodule

bind multi_timer_pwm_unit multi_timer_pwm_unit_asserts i_multi_timer_pwm_unit_asserts (
	.i_clk, .i_srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.i_power_down_mode, .o_counter_pin_out, .o_counter_pin_oe, .o_wake,
	.o_timer_one_irq_flag, .o_timer_two_irq_flag, .o_timer_three_irq_flag);

// ### tb/apb_cpu_model.sv
`timescale 1ns/1ps
module apb_cpu_model (
	input wire i_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// setup, then access held until ready; no fixed latency assumed
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ### tb/multi_timer_pwm_unit_tb.sv
`timescale 1ns/1ps
module multi_timer_pwm_unit_tb;
	logic i_clk, i_srst, i_power_down_mode, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [7:0] div = 8'h00;
	logic [31:0] pwdata, prdata, q;
	logic o_counter_pin_out, o_counter_pin_oe, o_prescaler_output, o_display_timer_underflow;
	logic o_wake, f1, f2, f3;
	int errors, n_tests, t0, c, np, n, m, k;
	int cyc = 0;
	wire [6:0] sig = {o_wake, o_counter_pin_out, o_display_timer_underflow,
		o_prescaler_output, f3, f2, f1};

	multi_timer_pwm_unit i_multi_timer_pwm_unit (.i_clk, .i_srst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .i_main_crystal_input(div[4]),
		.i_sub_crystal_input(div[5]), .i_low_osc(div[6]), .i_high_osc(div[3]),
		.i_counter_pin(div[5]), .i_ext_int_pin(div[7]), .i_power_down_mode,
		.o_counter_pin_out, .o_counter_pin_oe, .o_prescaler_output,
		.o_display_timer_underflow, .o_wake, .o_timer_one_irq_flag(f1),
		.o_timer_two_irq_flag(f2), .o_timer_three_irq_flag(f3));
	apb_cpu_model i_apb_cpu_model (.i_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Slow free-running sources keep the synchronised pins exercised
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		div <= div + 8'h01;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s: %0h vs %0h", $time, msg, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_apb_cpu_model.xfer(1'b1, a, d, q, e);
	endtask
	task rd(input logic [7:0] a);
		i_apb_cpu_model.xfer(1'b0, a, 32'h0, q, e);
	endtask
	task wt(input int i, input logic v);
		do @(posedge i_clk); while (sig[i] !== v);
	endtask
	// Sticky flags are cleared around the first event so the gap is a true period
	task gap(input int i, input bit clr);
		if (clr) wr(8'h38, 32'h7);
		wt(i, 1'b1);
		t0 = cyc;
		if (clr) wr(8'h38, 32'h7);
		wt(i, 1'b1);
		c = cyc - t0;
	endtask
	task width(input logic v);
		wt(5, !v);
		wt(5, v);
		t0 = cyc;
		wt(5, !v);
		c = cyc - t0;
	endtask
	task summarize;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		#400000;
		errors++;
		$display("CHECK FAILED %0t timeout", $time);
		summarize;
	end

	initial begin
		i_srst = 1'b1;
		i_power_down_mode = 1'b0;
		errors = 0;
		n_tests = 0;
		k = $urandom(32'hB218370E);
		repeat (12) @(posedge i_clk);
		i_srst <= 1'b0;
		rd(8'h24);
		check(q, 32'h0, "t3 ctrl");
		rd(8'h3C);
		check(q, 32'hFFFF, "t3 init");
		rd(8'h40);
		check({q[31:1], e}, 32'h1, "unmapped");
		$display("test reset done");
		np = 3 + $urandom % 13;
		wr(8'h04, np);
		rd(8'h04);
		check(q, np, "pre reload");
		wr(8'h00, 32'h1);
		gap(3, 0);
		check(c, np + 1, "pre period");
		$display("test prescaler done");
		n = 1 + $urandom % 7;
		wr(8'h0C, n);
		wr(8'h08, 32'h0);
		wr(8'h08, 32'h4);
		gap(0, 1);
		check(c, (n + 1) * (np + 1), "t1 period");
		wr(8'h08, 32'h0);
		wr(8'h34, 32'h1);
		wr(8'h0C, n);
		wr(8'h38, 32'h7);
		wr(8'h08, 32'hE);
		wt(0, 1'b1);
		rd(8'h0C);
		check(q, n, "auto-stop");
		wr(8'h08, 32'h0);
		wr(8'h34, 32'h0);
		$display("test timer one done");
		for (k = 0; k < 2; k++) begin
			n = 1 + $urandom % 4;
			m = 1 + $urandom % 4;
			wr(8'h14, 32'h0);
			repeat (300) @(posedge i_clk);
			wr(8'h18, n);
			wr(8'h1C, m);
			wr(8'h14, 32'hB | (k << 2));
			width(1'b0);
			check(c, 2 * (n + 1) * (np + 1), "pwm low");
			width(1'b1);
			check(c, (2 * m + 2 + k) * (np + 1), "pwm high");
			check(o_counter_pin_oe, 32'h1, "pin oe");
		end
		wr(8'h14, 32'h0);
		$display("test pwm done");
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h1);
		for (k = 0; k < 2; k++) begin
			wr(8'h2C, 32'h1);
			wr(8'h24, 32'h8 | k);
			gap(2, 1);
			check(c, 512 << k, "t3 length");
			wr(8'h24, 32'h0);
			rd(8'h3C);
			check(q, 32'hFFFF, "t3 stop");
		end
		wr(8'h24, 32'h8);
		@(posedge i_clk);
		i_power_down_mode <= 1'b1;
		wt(6, 1'b1);
		check(f3, 32'h1, "wake flag");
		i_power_down_mode <= 1'b0;
		wr(8'h24, 32'h0);
		$display("test timer three done");
		n = 1 + $urandom % 15;
		wr(8'h28, 32'h0);
		wr(8'h30, n);
		wr(8'h28, 32'hC);
		gap(4, 0);
		check(c, n + 1, "lc period");
		$display("test display timer done");
		summarize;
	end
endmodule
